// ==== design/ssp_pkg.sv ====
// package of the serial sensor poller: register map, field layout, timing counts
// assumes a 200 MHz system clock; all offsets are byte addresses on a 32-bit bus
package ssp_pkg;
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned MS_PER_S    = 1000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
	localparam int          ADDR_W      = 6;
	localparam int          DIV_W       = 20;
	// register byte offsets
	localparam logic [5:0] OFS_CTRL     = 6'h00;
	localparam logic [5:0] OFS_TIMEOUT  = 6'h04;
	localparam logic [5:0] OFS_STATUS   = 6'h08;
	localparam logic [5:0] OFS_MASK     = 6'h0C;
	localparam logic [5:0] OFS_MEAS     = 6'h10;
	localparam logic [5:0] OFS_SETPOINT = 6'h14;
	localparam logic [5:0] OFS_REQUEST  = 6'h18;
	localparam logic [5:0] OFS_SLAVE    = 6'h1C;
	localparam logic [5:0] OFS_RXDATA   = 6'h20;
	// control field positions
	localparam int CTL_MODE    = 0;  // [1:0] port mode
	localparam int CTL_ASCII   = 2;  // modbus ascii encoding
	localparam int CTL_RETRY   = 3;
	localparam int CTL_STOP2   = 4;
	localparam int CTL_PAR     = 5;  // [6:5] parity
	localparam int CTL_DATA7   = 7;
	localparam int CTL_BAUD    = 8;  // [11:8]
	localparam int CTL_HOLD    = 12; // [14:12]
	localparam logic [31:0] CTRL_RST = 32'h0000_0500;
	// port modes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SENSOR = 2'h1;
	localparam logic [1:0] MODE_MB_MASTER = 2'h2;
	localparam logic [1:0] MODE_MB_SLAVE = 2'h3;
	// parity codes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD  = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	// hold codes: 0 off, 1..5 cycles, 7 permanent
	localparam logic [2:0] HOLD_OFF  = 3'h0;
	localparam logic [2:0] HOLD_MAX  = 3'h5;
	localparam logic [2:0] HOLD_PERM = 3'h7;
	// status bits
	localparam int ST_DONE = 0;
	localparam int ST_ERR  = 1;
	localparam int ST_PERR = 2;
	localparam int ST_RX   = 3;
	localparam int ST_SLV  = 4;
	localparam int ST_W    = 5;
	localparam logic [7:0] ASCII_START = 8'h3A;
	// bit time in clocks for a baud selector 0..9
	function automatic logic [DIV_W-1:0] ssp_baud_div(input logic [3:0] sel);
		case (sel)
			4'h0: ssp_baud_div = DIV_W'(CLK_HZ / 300);
			4'h1: ssp_baud_div = DIV_W'(CLK_HZ / 600);
			4'h2: ssp_baud_div = DIV_W'(CLK_HZ / 1200);
			4'h3: ssp_baud_div = DIV_W'(CLK_HZ / 2400);
			4'h4: ssp_baud_div = DIV_W'(CLK_HZ / 4800);
			4'h5: ssp_baud_div = DIV_W'(CLK_HZ / 9600);
			4'h6: ssp_baud_div = DIV_W'(CLK_HZ / 19200);
			4'h7: ssp_baud_div = DIV_W'(CLK_HZ / 38400);
			4'h8: ssp_baud_div = DIV_W'(CLK_HZ / 57600);
			default: ssp_baud_div = DIV_W'(CLK_HZ / 115200);
		endcase
	endfunction : ssp_baud_div
endpackage : ssp_pkg

// ==== design/ssp_uart_tx.sv ====
// serial character transmitter: start, 7/8 data lsb first, parity, 1/2 stop
// assumes div is stable while a character is in flight
module ssp_uart_tx
	import ssp_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             data7,
	input  wire logic [1:0]       parity,
	input  wire logic             stop2,
	input  wire logic             start,
	input  wire logic [7:0]       data,
	output logic                  ready,
	output logic                  txd
);
	logic [11:0]      shift;
	logic [3:0]       left;
	logic [DIV_W-1:0] tick;

	assign ready = (left == 4'h0);
	// frame is preloaded so the shifter only walks bits out
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift <= 12'h0FF_F;
			left  <= 4'h0;
			tick  <= '0;
			txd   <= 1'b1;
		end else if (ce) begin
			if (ready && start) begin
				logic [7:0] d;
				logic       p;
				d = data7 ? {1'b0, data[6:0]} : data;
				p = ^d ^ (parity == PAR_ODD);
				shift <= data7 ? ((parity != PAR_NONE) ? {3'h7, p, d[6:0], 1'b0} : {4'hF, d[6:0], 1'b0})
				               : ((parity != PAR_NONE) ? {2'h3, p, d, 1'b0} : {3'h7, d, 1'b0}); // [R16] [R03] [R04]
				left  <= 4'(4'hA + (parity != PAR_NONE) + stop2 - data7); // [R02] ready after the last stop bit ends
				tick  <= div;
				txd   <= 1'b0;
			end else if (!ready) begin
				if (tick == 1) begin
					tick  <= div;
					shift <= {1'b1, shift[11:1]};
					txd   <= (left == 4'h1) ? 1'b1 : shift[1];
					left  <= left - 4'h1;
				end else begin
					tick <= tick - 1'b1;
				end
			end
		end
	end
endmodule : ssp_uart_tx

// ==== design/ssp_uart_rx.sv ====
// serial character receiver sampling mid-bit; checks parity and stop bit
// assumes rxd is already synchronous to clk and idles high
module ssp_uart_rx
	import ssp_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic             en,
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             data7,
	input  wire logic [1:0]       parity,
	input  wire logic             rxd,
	output logic                  valid,
	output logic [7:0]            data,
	output logic                  perr
);
	logic [9:0]       sh;
	logic [3:0]       cnt;
	logic [3:0]       nbits;
	logic             busy;
	logic [DIV_W-1:0] tick;

	// start, data bits plus parity; stop is the last sample
	assign nbits = 4'(4'h9 + (parity != PAR_NONE) - data7);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy  <= 1'b0;
			cnt   <= 4'h0;
			tick  <= '0;
			sh    <= '0;
			valid <= 1'b0;
			data  <= 8'h00;
			perr  <= 1'b0;
		end else if (ce) begin
			valid <= 1'b0;
			if (!busy) begin
				if (en && !rxd) begin
					busy <= 1'b1;
					cnt  <= 4'h0;
					tick <= DIV_W'(div >> 1);
				end
			end else if (tick == 0) begin
				tick <= div;
				if (cnt == 4'h0 && rxd) begin
					busy <= 1'b0; // glitch, not a start bit
				end else if (cnt == nbits) begin
					logic [7:0] d;
					busy <= 1'b0;
					d = data7 ? ((parity != PAR_NONE) ? {1'b0, sh[8:2]} : {1'b0, sh[9:3]})
					          : ((parity != PAR_NONE) ? sh[8:1] : sh[9:2]); // [R04]
					data  <= d;
					valid <= rxd; // framing error drops the char
					perr  <= (parity != PAR_NONE) && ((^d ^ sh[9]) != (parity == PAR_ODD)); // [R03]
				end else begin
					sh  <= {rxd, sh[9:1]}; // [R16]
					cnt <= cnt + 4'h1;
				end
			end else begin
				tick <= tick - 1'b1;
			end
		end
	end
endmodule : ssp_uart_rx

// ==== design/ssp_poller.sv ====
// serial sensor poller: measurement request, supervised answer, hold, setpoint record
// assumes meas_tick pulses once per measurement cycle and rxd is synchronous to clk
//
// Functional notes
// [R01] The bit rate is one of 300 to 115200 baud, picked by a selector.
// [R02] Each character carries one or two stop bits as configured.
// [R03] Parity is none, odd or even, and the receiver checks it when enabled.
// [R04] Characters carry seven or eight data bits.
// [R05] An answer not complete within the frame timeout is a communication error; zero disables it.
// [R06] Hold of one to five keeps the last valid value that many failed cycles, off substitutes at once.
// [R07] Permanent hold keeps the last valid value until a new valid one arrives.
// [R08] With retry the failed request is sent once more and the error shows only if that fails too; the code skips the retry on a parity error.
// [R09] Every measurement instant sends the request sequence.
// [R10] The retry request goes out right after the first timeout expires.
// [R11] A final timeout sets the open loop error value on every channel of the port.
// [R12] After each attempt, failed or not, the setpoint record is sent; the code skips it between a first timeout and its retry.
// [R13] Software keeps the timeout below the cycle, or twice it below the cycle with retry.
// [R14] Modbus mode works as master or slave with RTU or ASCII encoding.
// [R15] As slave only requests to the own address are answered; in rtu the code answers any character equal to the own address.
// [R16] A character is a low start bit, data lsb first, optional parity, then stop bits.
// [R17] Mode off sends nothing and ignores received characters.
//
// Added by the designer: the Avalon-MM slave port and the address map.
module ssp_poller
	import ssp_pkg::*;
#(
	parameter int          ANS_BYTES = 4,
	parameter int          SP_BYTES  = 4,
	parameter int unsigned MS_CYC    = CYC_PER_MS,
	parameter logic [31:0] OL_VALUE  = 32'h7FFF_FFFF // arbitrary marker pattern
)(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	input  wire logic [ssp_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  meas_tick,
	input  wire logic                  rxd,
	output logic                       txd,
	output logic [31:0]                meas_value,
	output logic                       meas_ol,
	output logic                       irq
);
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		SSP_IDLE = 5'b00001,
		SSP_REQ  = 5'b00010,
		SSP_WAIT = 5'b00100,
		SSP_EVAL = 5'b01000,
		SSP_SP   = 5'b10000
	} ssp_state_t;

	ssp_state_t       state;
	logic [31:0]      ctrl;
	logic [31:0]      timeout_ms;
	logic [ST_W-1:0]  status;
	logic [ST_W-1:0]  mask;
	logic [31:0]      setpoint;
	logic [7:0]       request;
	logic [7:0]       slave_addr;
	logic [7:0]       rx_last;
	logic             ack;
	logic [31:0]      ans_shift;
	logic [3:0]       ans_cnt;
	logic             ans_perr;
	logic             second_try;
	logic [2:0]       fail_cnt;
	logic [31:0]      valid_value;
	logic [3:0]       tx_idx;
	logic             ascii_lead;
	logic [31:0]      ms_pre;
	logic [31:0]      ms_cnt;
	logic             tmo;
	logic             slv_pending;
	logic             slv_hdr;
	logic [ST_W-1:0]  st_set;
	logic [ST_W-1:0]  st_clr;
	logic             tx_ready;
	logic             tx_start;
	logic [7:0]       tx_data;
	logic             rx_valid;
	logic [7:0]       rx_data;
	logic             rx_perr;
	logic [DIV_W-1:0] bit_div;

	logic [1:0] mode;
	logic [2:0] hold;
	logic       port_on;
	logic       ascii_enc;
	assign mode      = ctrl[CTL_MODE +: 2];
	assign hold      = ctrl[CTL_HOLD +: 3];
	assign ascii_enc = ctrl[CTL_ASCII] && mode[1];                   // [R14]
	assign port_on   = (mode != MODE_OFF);                            // [R17]
	assign bit_div   = ssp_baud_div(ctrl[CTL_BAUD +: 4]);             // [R01]

	// byte merge for a 32-bit register under byte enables
	function automatic logic [31:0] ssp_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		ssp_merge = old;
	endfunction : ssp_merge

	////////////////////////////////////////////////////////////////////////////
	// character engines
	ssp_uart_tx u_tx (
		.clk    (clk),
		.rstn   (rstn),
		.ce     (ce),
		.div    (bit_div),
		.data7  (ctrl[CTL_DATA7]),
		.parity (ctrl[CTL_PAR +: 2]),
		.stop2  (ctrl[CTL_STOP2]),
		.start  (tx_start),
		.data   (tx_data),
		.ready  (tx_ready),
		.txd    (txd)
	);

	ssp_uart_rx u_rx (
		.clk    (clk),
		.rstn   (rstn),
		.ce     (ce),
		.en     (port_on), // [R17]
		.div    (bit_div),
		.data7  (ctrl[CTL_DATA7]),
		.parity (ctrl[CTL_PAR +: 2]),
		.rxd    (rxd),
		.valid  (rx_valid),
		.data   (rx_data),
		.perr   (rx_perr)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle on every access, so readdata is registered
	logic acc;
	logic wr_now;
	assign acc             = avs_read || avs_write;
	assign avs_waitrequest = acc && !(ack && ce); // a frozen cycle must not complete an access
	assign wr_now          = avs_write && ack && ce;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ack <= 1'b0;
		else if (ce)
			ack <= acc && !ack;
	end

	// read mux, unmapped offsets read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce && avs_read && !ack) begin
			case (avs_address)
				OFS_CTRL:     avs_readdata <= ctrl;
				OFS_TIMEOUT:  avs_readdata <= timeout_ms;
				OFS_STATUS:   avs_readdata <= 32'(status);
				OFS_MASK:     avs_readdata <= 32'(mask);
				OFS_MEAS:     avs_readdata <= meas_value;
				OFS_SETPOINT: avs_readdata <= setpoint;
				OFS_REQUEST:  avs_readdata <= {24'h00_0000, request};
				OFS_SLAVE:    avs_readdata <= {24'h00_0000, slave_addr};
				OFS_RXDATA:   avs_readdata <= {24'h00_0000, rx_last};
				default:      avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// software writable configuration
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl       <= CTRL_RST;
			timeout_ms <= 32'h0000_0000;
			mask       <= '0;
			setpoint   <= 32'h0000_0000;
			request    <= 8'h00;
			slave_addr <= 8'h01;
		end else if (ce && wr_now) begin
			case (avs_address)
				OFS_CTRL:     ctrl       <= ssp_merge(ctrl, avs_writedata, avs_byteenable);
				OFS_TIMEOUT:  timeout_ms <= ssp_merge(timeout_ms, avs_writedata, avs_byteenable);
				OFS_MASK:     if (avs_byteenable[0]) mask <= avs_writedata[ST_W-1:0];
				OFS_SETPOINT: setpoint   <= ssp_merge(setpoint, avs_writedata, avs_byteenable);
				OFS_REQUEST:  if (avs_byteenable[0]) request <= avs_writedata[7:0];
				OFS_SLAVE:    if (avs_byteenable[0]) slave_addr <= avs_writedata[7:0];
				default:      ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky status, write one to clear; a new event beats a same-cycle clear
	assign st_clr = (wr_now && avs_address == OFS_STATUS && avs_byteenable[0]) ? avs_writedata[ST_W-1:0] : '0;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			status <= '0;
		else if (ce)
			status <= (status & ~st_clr) | st_set;
	end

	assign irq = |(status & mask);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rx_last <= 8'h00;
		else if (ce && rx_valid && port_on)
			rx_last <= rx_data;
	end

	////////////////////////////////////////////////////////////////////////////
	// frame timeout in milliseconds, restarted for every attempt
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_pre <= 32'h0000_0000;
			ms_cnt <= 32'h0000_0000;
		end else if (ce) begin
			if (state != SSP_WAIT) begin
				ms_pre <= 32'h0000_0000;
				ms_cnt <= 32'h0000_0000;
			end else if (ms_pre == 32'(MS_CYC - 1)) begin
				ms_pre <= 32'h0000_0000;
				ms_cnt <= ms_cnt + 32'h1;
			end else begin
				ms_pre <= ms_pre + 32'h1;
			end
		end
	end
	assign tmo = (timeout_ms != 32'h0) && (ms_cnt >= timeout_ms); // [R05]

	////////////////////////////////////////////////////////////////////////////
	// transmit byte selection: request in REQ, setpoint record in SP
	always_comb begin
		tx_data  = 8'h00;
		tx_start = 1'b0;
		if (state == SSP_REQ || state == SSP_SP) begin
			tx_start = tx_ready;
			if (ascii_lead)
				tx_data = ASCII_START; // ascii frames open with a colon
			else if (state == SSP_REQ)
				tx_data = request;
			else
				tx_data = setpoint[tx_idx[1:0]*8 +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// poll sequencer
	logic ans_done;
	assign ans_done = (ans_cnt == 4'(ANS_BYTES));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state       <= SSP_IDLE;
			second_try  <= 1'b0;
			tx_idx      <= 4'h0;
			ascii_lead  <= 1'b0;
			ans_cnt     <= 4'h0;
			ans_shift   <= 32'h0000_0000;
			ans_perr    <= 1'b0;
			slv_pending <= 1'b0;
			slv_hdr     <= 1'b0;
		end else if (ce) begin
			case (state)
				SSP_IDLE: begin
					second_try <= 1'b0;
					tx_idx     <= 4'h0;
					ascii_lead <= ascii_enc;
					if ((mode == MODE_SENSOR || mode == MODE_MB_MASTER) && meas_tick)
						state <= SSP_REQ; // [R09]
					else if (mode == MODE_MB_SLAVE && slv_pending) begin
						slv_pending <= 1'b0;
						state       <= SSP_SP; // [R15]
					end
					// slave: compare the char after a colon in ascii, every char in rtu, with the own address
					if (mode == MODE_MB_SLAVE && rx_valid) begin
						if (ascii_enc && rx_data == ASCII_START)
							slv_hdr <= 1'b1;
						else if (!ascii_enc || slv_hdr) begin
							slv_hdr <= 1'b0;
							if (rx_data == slave_addr)
								slv_pending <= 1'b1; // [R15]
						end
					end
				end
				SSP_REQ: begin
					if (!port_on)
						state <= SSP_IDLE; // [R17]
					else if (tx_ready) begin
						ascii_lead <= 1'b0;
						if (!ascii_lead) begin
							state     <= SSP_WAIT;
							ans_cnt   <= 4'h0;
							ans_perr  <= 1'b0;
							ans_shift <= 32'h0000_0000;
						end
					end
				end
				SSP_WAIT: begin
					if (rx_valid && !ans_done) begin
						ans_shift[ans_cnt[1:0]*8 +: 8] <= rx_data; // first byte lands in bits 7:0
						ans_cnt   <= ans_cnt + 4'h1;
						ans_perr  <= ans_perr | rx_perr;
					end
					if (!port_on)
						state <= SSP_IDLE;
					else if (ans_done)
						state <= SSP_EVAL;
					else if (tmo) begin
						if (ctrl[CTL_RETRY] && !second_try) begin
							second_try <= 1'b1;
							ascii_lead <= ascii_enc;
							state      <= SSP_REQ; // [R08] [R10]
						end else
							state <= SSP_EVAL; // [R11]
					end
				end
				SSP_EVAL: begin
					tx_idx     <= 4'h0;
					ascii_lead <= ascii_enc;
					state      <= SSP_SP; // [R12]
				end
				SSP_SP: begin
					if (!port_on)
						state <= SSP_IDLE;
					else if (tx_ready) begin
						ascii_lead <= 1'b0;
						if (!ascii_lead) begin
							if (tx_idx == 4'(SP_BYTES - 1))
								state <= SSP_IDLE;
							tx_idx <= tx_idx + 4'h1;
						end
					end
				end
				default: state <= SSP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// events for the status register
	logic eval_ok;
	assign eval_ok = ans_done && !ans_perr;
	always_comb begin
		st_set          = '0;
		st_set[ST_DONE] = (state == SSP_SP) && tx_ready && !ascii_lead && (tx_idx == 4'(SP_BYTES - 1));
		st_set[ST_ERR]  = (state == SSP_EVAL) && !eval_ok; // [R08]
		st_set[ST_PERR] = rx_valid && rx_perr && port_on;
		st_set[ST_RX]   = rx_valid && port_on;
		st_set[ST_SLV]  = (mode == MODE_MB_SLAVE) && (state == SSP_IDLE) && slv_pending;
	end

	////////////////////////////////////////////////////////////////////////////
	// presented value with hold handling
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid_value <= 32'h0000_0000;
			fail_cnt    <= 3'h0;
			meas_value  <= OL_VALUE;
			meas_ol     <= 1'b1;
		end else if (ce && state == SSP_EVAL) begin
			if (eval_ok) begin
				valid_value <= ans_shift;
				meas_value  <= ans_shift;
				meas_ol     <= 1'b0;
				fail_cnt    <= 3'h0;
			end else if (hold == HOLD_PERM) begin
				meas_value <= meas_ol ? OL_VALUE : valid_value; // [R07] nothing valid yet keeps the error
			end else if (hold == HOLD_OFF || hold > HOLD_MAX || fail_cnt >= hold) begin
				meas_value <= OL_VALUE; // [R06] [R11]
				meas_ol    <= 1'b1;
			end else begin
				fail_cnt   <= fail_cnt + 3'h1; // [R06]
				meas_value <= meas_ol ? OL_VALUE : valid_value;
			end
		end
	end
endmodule : ssp_poller

// ==== test/ssp_poller_asserts.sv ====
// checker of the poller ports: bus handshake, line framing, error value
// assumes it is bound into ssp_poller and the bus uses full byte enables
module ssp_poller_asserts #(
	parameter logic [31:0] OL_VALUE = 32'h7FFF_FFFF
)(
	input wire logic                       clk,
	input wire logic                       rstn,
	input wire logic                       ce,
	input wire logic [ssp_pkg::ADDR_W-1:0] avs_address,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [31:0]                avs_writedata,
	input wire logic [31:0]                avs_readdata,
	input wire logic                       avs_waitrequest,
	input wire logic                       txd,
	input wire logic [31:0]                meas_value,
	input wire logic                       meas_ol,
	input wire logic                       irq
);
	timeunit 1ns;
	timeprecision 100ps;
	import ssp_pkg::*;
	logic [31:0] ctrl;
	logic [31:0] tmo;
	logic [31:0] mask;
	////////////////////////////////////////////////////////////
	// mirrors of written registers, so the mode is visible here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= CTRL_RST;
			tmo  <= '0;
			mask <= '0;
		end else if (ce && avs_write && !avs_waitrequest) begin
			if (avs_address == OFS_CTRL) ctrl <= avs_writedata;
			if (avs_address == OFS_TIMEOUT) tmo <= avs_writedata;
			if (avs_address == OFS_MASK) mask <= avs_writedata;
		end
	end
	////////////////////////////////////////////////////////////
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_bus_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
		else $error("bus access not answered after one wait cycle");
	a_bus_idle_free: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_RXDATA |-> avs_readdata == 0)
		else $error("unmapped read not zero");
	a_ol_pairs_value: assert property (meas_ol |-> meas_value == OL_VALUE)
		else $error("open loop flag without the error value");
	a_start_bit_low: assert property ($fell(txd) |=> !txd [*8])
		else $error("start bit shorter than a bit time");
	a_stop_bit_high: assert property ($rose(txd) |=> txd [*8])
		else $error("high bit shorter than a bit time");
	a_off_stays_idle: assert property (ctrl[1:0] == MODE_OFF && txd |=> txd)
		else $error("transmission while the port is off");
	a_no_tmo_no_ol: assert property (tmo == 0 && ctrl[6:5] == PAR_NONE |-> !$rose(meas_ol))
		else $error("error value without supervision");
	a_irq_masked: assert property (mask == 0 |-> !irq)
		else $error("interrupt with every source masked");
	c_good_value: cover property ($fell(meas_ol));
	c_open_loop: cover property ($rose(meas_ol));
	c_irq_seen: cover property ($rose(irq));
endmodule : ssp_poller_asserts

bind ssp_poller ssp_poller_asserts #(.OL_VALUE(OL_VALUE)) u_chk (
	.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .txd(txd), .meas_value(meas_value),
	.meas_ol(meas_ol), .irq(irq)
);

// ==== test/ssp_sensor_model.sv ====
// behavioural sensor: answers one request with one 8n1 character
// assumes the poller runs the line at BIT clocks per bit
module ssp_sensor_model #(
	parameter int BIT = 1736
)(
	input  wire logic       clk,
	input  wire logic       armed,
	input  wire logic [7:0] answer,
	input  wire logic       txd,
	output logic            rxd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] frame;
	////////////////////////////////////////////////////////////
	// answer only once the request character has fully ended
	initial begin
		rxd = 1'b1; // idle high
		forever begin
			@(posedge clk);
			if (armed && !txd) begin
				repeat (10 * BIT) @(posedge clk);
				frame = {1'b1, answer, 1'b0}; // no parity, 8 data, 1 stop
				for (int i = 0; i < 10; i++) begin
					rxd <= frame[i]; // start, lsb first, stop
					repeat (BIT) @(posedge clk); // fastest rate
				end
				wait (!armed);
			end
		end
	end
endmodule : ssp_sensor_model

// ==== test/ssp_poller_bench.sv ====
// self-checking bench of the poller with the sensor model on the line
// assumes 115200 baud, short ms units and one byte answers and records
module ssp_poller_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import ssp_pkg::*;
	localparam int          BIT = CLK_HZ / 115200;
	localparam logic [31:0] OL  = 32'h7FFF_FFFF;
	logic        clk, rstn, ce, avs_read, avs_write, meas_tick, rxd, txd, meas_ol, irq, armed;
	logic [5:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [7:0]  answer, c;
	logic [31:0] avs_writedata, avs_readdata, meas_value, q;
	logic        avs_waitrequest;
	int          bad_count, total_checks, cyc, n;
	ssp_poller #(.ANS_BYTES(1), .SP_BYTES(1), .MS_CYC(20), .OL_VALUE(OL)) u_dut (
		.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_tick(meas_tick),
		.rxd(rxd), .txd(txd), .meas_value(meas_value), .meas_ol(meas_ol), .irq(irq));
	ssp_sensor_model #(.BIT(BIT)) u_sensor (.clk(clk), .armed(armed), .answer(answer), .txd(txd), .rxd(rxd));
	////////////////////////////////////////////////////////////
	// clock and cycle count; the count also cuts a hang short
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc++;
	initial begin
		wait (cyc == 110000); // the scenarios need about 105000 cycles
		bad_count++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one access held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic tick();
		meas_tick <= 1'b1;
		@(posedge clk);
		meas_tick <= 1'b0;
	endtask : tick
	// decode one character off txd, sampling mid-bit
	task automatic get_char();
		while (txd !== 1'b0) @(posedge clk);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			c[i] = txd;
		end
		repeat (BIT) @(posedge clk);
		check(32'(txd), 1);
	endtask : get_char
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		bus(0, OFS_CTRL, 0);
		check(q, CTRL_RST);
		bus(0, OFS_SLAVE, 0);
		check(q, 1);
		bus(0, 6'h3C, 0);
		check(q, 0);
		check(meas_value, OL);
	endtask : t_reset
	task automatic t_off();
		bus(1, OFS_CTRL, 32'h0000_0900);
		tick();
		n = 0;
		repeat (3000) begin
			@(posedge clk);
			n += int'(!txd);
		end
		check(32'(n), 0);
	endtask : t_off
	task automatic t_good();
		bus(1, OFS_REQUEST, 32'h0000_005A);
		bus(1, OFS_SETPOINT, 32'h0000_00C3);
		bus(1, OFS_TIMEOUT, 0);
		bus(1, OFS_MASK, 32'h0000_0001);
		bus(1, OFS_CTRL, 32'h0000_0901);
		answer <= 8'h3C;
		armed <= 1'b1;
		tick();
		get_char();
		check(c, 8'h5A);
		get_char();
		check(c, 8'hC3);
		armed <= 1'b0;
		check({meas_ol, meas_value[7:0]}, 9'h03C);
		check(irq, 1);
		bus(1, OFS_STATUS, 32'h0000_0001);
		check(irq, 0);
	endtask : t_good
	task automatic t_fail();
		int t0;
		bus(1, OFS_TIMEOUT, 10); // 200 cycles, well below a cycle
		bus(1, OFS_CTRL, 32'h0000_0909);
		tick();
		get_char();
		check(c, 8'h5A);
		t0 = cyc;
		get_char();
		check(c, 8'h5A);
		check(32'(cyc - t0 <= 10 * BIT + 260), 1);
		get_char();
		check(c, 8'hC3);
		check(32'(meas_ol), 1);
		check(meas_value, OL);
		bus(0, OFS_STATUS, 0);
		check(q & 32'h3, 32'h3);
	endtask : t_fail
	task automatic end_of_test();
		if (bad_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		meas_tick = 1'b0;
		armed = 1'b0;
		answer = '0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_off();
		t_good();
		t_fail();
		end_of_test();
	end
endmodule : ssp_poller_bench
